/* File: include/stc_consts.svh */
`ifndef STC_CONSTS_SVH
`define STC_CONSTS_SVH

// Register byte addresses
`define STC_OFF_CSR 32'he000e010
`define STC_OFF_RESTART 32'he000e014
`define STC_OFF_COUNT 32'he000e018
`define STC_OFF_CALIBRATION_REG 32'he000e01c
`define STC_OFF_EVT_STATUS 32'he000e020
`define STC_OFF_EVT_ENABLE 32'he000e024
`define STC_OFF_EVT_CLEAR 32'he000e028

// Control/status field positions
`define STC_BIT_ENABLE 0
`define STC_BIT_IRQ_EN 1
`define STC_BIT_SOURCE 2
`define STC_BIT_WRAP 16

// Reset values
`define STC_RST_CSR 32'h0000_0004
`define STC_RST_RESTART 24'h00_0000
`define STC_RST_COUNT 24'h00_0000
`define STC_CALIBRATION_REG_VALUE 32'h0000_2904

// Timing
`define STC_DIV_RATIO 8
`define STC_DIV_LAST 3'h7
`define STC_CNT_W 24

`endif

/* File: include/stc_pkg.sv */
package stc_pkg;

    // Bus answer phase
    typedef enum logic {
        STC_BUS_IDLE,
        STC_BUS_ANSWER
    } stc_bus_type;

endpackage

/* File: core/stc_tick_timer.sv */
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "stc_consts.svh"

module stc_tick_timer (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Avalon-MM slave
    input wire logic [31:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Processor state pins
    input wire logic debug_halt_in,
    input wire logic clock_stop_in,
    // Requests
    output logic tick_exc_req,
    output logic irq
);

    function automatic logic hit(input logic [31:0] a,
                                 input logic [31:0] off);
        hit = (a == off);
    endfunction

    localparam int CW = `STC_CNT_W;

    stc_pkg::stc_bus_type bus_q;
    logic acc;
    logic acc_rd;
    logic acc_wr;
    logic [1:0] sync1_q;
    logic [1:0] sync2_q;
    logic halt_s;
    logic stop_s;
    logic [2:0] div_q;
    logic div_pulse;
    logic tick;
    logic en_q;
    logic irq_en_q;
    logic src_q;
    logic wrap_q;
    logic load_pend_q;
    logic [CW-1:0] restart_q;
    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;
    logic wrap_evt;
    logic csr_rd;
    logic csr_wr;
    logic cnt_wr;
    logic evt_status_q;
    logic evt_enable_q;
    logic [31:0] rdata_d;

    // One wait cycle, then answer
    assign acc = (read | write) & (bus_q == stc_pkg::STC_BUS_IDLE);
    assign acc_rd = acc & read;
    assign acc_wr = acc & write & (&byteenable);
    assign waitrequest = (read | write) &
                         (bus_q == stc_pkg::STC_BUS_IDLE);

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            bus_q <= stc_pkg::STC_BUS_IDLE;
        end else begin
            case (bus_q)
                stc_pkg::STC_BUS_IDLE: begin
                    if (read | write) begin
                        bus_q <= stc_pkg::STC_BUS_ANSWER;
                    end
                end
                stc_pkg::STC_BUS_ANSWER: begin
                    bus_q <= stc_pkg::STC_BUS_IDLE;
                end
                default: begin
                    bus_q <= stc_pkg::STC_BUS_IDLE;
                end
            endcase
        end
    end

    assign csr_rd = acc_rd & hit(address, `STC_OFF_CSR);
    assign csr_wr = acc_wr & hit(address, `STC_OFF_CSR);
    assign cnt_wr = acc_wr & hit(address, `STC_OFF_COUNT);

    // Pin inputs: two flops before any use
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sync1_q <= 2'h0;
            sync2_q <= 2'h0;
        end else begin
            sync1_q <= {clock_stop_in, debug_halt_in};
            sync2_q <= sync1_q;
        end
    end

    assign halt_s = sync2_q[0];
    assign stop_s = sync2_q[1];

    // Divider freezes with the clock stop too
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            div_q <= 3'h0;
        end else if (!stop_s) begin
            div_q <= div_q + 3'h1;
        end
    end

    assign div_pulse = (div_q == `STC_DIV_LAST);

    // Counter advance enable
    assign tick = en_q & ~halt_s & ~stop_s &
                  (src_q | div_pulse);

    // Control fields
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            en_q <= 1'b0;
            irq_en_q <= 1'b0;
            src_q <= 1'b1;
        end else if (csr_wr) begin
            en_q <= writedata[`STC_BIT_ENABLE];
            irq_en_q <= writedata[`STC_BIT_IRQ_EN];
            src_q <= writedata[`STC_BIT_SOURCE];
        end
    end

    // Enabling defers a load to the first tick
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            load_pend_q <= 1'b0;
        end else if (csr_wr && writedata[`STC_BIT_ENABLE] && !en_q) begin
            load_pend_q <= 1'b1;
        end else if (tick) begin
            load_pend_q <= 1'b0;
        end
    end

    // New restart value waits for the next reload
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            restart_q <= `STC_RST_RESTART;
        end else if (acc_wr && hit(address, `STC_OFF_RESTART)) begin
            restart_q <= writedata[CW-1:0];
        end
    end

    // Wrap only on a 1 to 0 step, never on reload of 0
    assign wrap_evt = tick & ~load_pend_q &
                      (count_q == 24'h00_0001) & ~cnt_wr;

    always_comb begin
        count_d = count_q;
        if (cnt_wr) begin
            count_d = `STC_RST_COUNT;
        end else if (tick) begin
            if (load_pend_q || count_q == 24'h00_0000) begin
                count_d = restart_q;
            end else begin
                count_d = count_q - 24'h00_0001;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= `STC_RST_COUNT;
        end else begin
            count_q <= count_d;
        end
    end

    // Set wins over the read clear
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wrap_q <= 1'b0;
        end else if (wrap_evt) begin
            wrap_q <= 1'b1;
        end else if (csr_rd || cnt_wr) begin
            wrap_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            tick_exc_req <= 1'b0;
        end else begin
            tick_exc_req <= wrap_evt & irq_en_q;
        end
    end

    // Sticky event status, enable and clear
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            evt_status_q <= 1'b0;
        end else if (wrap_evt) begin
            evt_status_q <= 1'b1;
        end else if (acc_wr && hit(address, `STC_OFF_EVT_CLEAR) &&
                     writedata[0]) begin
            evt_status_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            evt_enable_q <= 1'b0;
        end else if (acc_wr && hit(address, `STC_OFF_EVT_ENABLE)) begin
            evt_enable_q <= writedata[0];
        end
    end

    assign irq = evt_status_q & evt_enable_q;

    // Read mux; unmapped reads return zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (hit(address, `STC_OFF_CSR)) begin
            rdata_d[`STC_BIT_ENABLE] = en_q;
            rdata_d[`STC_BIT_IRQ_EN] = irq_en_q;
            rdata_d[`STC_BIT_SOURCE] = src_q;
            rdata_d[`STC_BIT_WRAP] = wrap_q;
        end else if (hit(address, `STC_OFF_RESTART)) begin
            rdata_d[CW-1:0] = restart_q;
        end else if (hit(address, `STC_OFF_COUNT)) begin
            rdata_d[CW-1:0] = count_q;
        end else if (hit(address, `STC_OFF_CALIBRATION_REG)) begin
            rdata_d = `STC_CALIBRATION_REG_VALUE;
        end else if (hit(address, `STC_OFF_EVT_STATUS)) begin
            rdata_d[0] = evt_status_q;
        end else if (hit(address, `STC_OFF_EVT_ENABLE)) begin
            rdata_d[0] = evt_enable_q;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            readdata <= 32'h0000_0000;
        end else if (acc_rd) begin
            readdata <= rdata_d;
        end
    end

    a_wrap_reload: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        (tick && !load_pend_q && count_q == 24'h00_0000 && !cnt_wr)
        |=> count_q == $past(restart_q))
        else $error("count did not reload after zero");

    a_halt_hold: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        (halt_s && !cnt_wr) |=> $stable(count_q))
        else $error("count moved during debug halt");

    a_flag_read: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        (csr_rd && wrap_q && !wrap_evt) |=> !wrap_q)
        else $error("wrap flag survived a read");

    a_div_source: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        (!src_q && div_q != `STC_DIV_LAST) |-> !tick)
        else $error("divided source ticked off its slot");

    a_exc_gate: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        tick_exc_req |-> $past(irq_en_q) && $past(wrap_evt))
        else $error("exception request without enabled wrap");

    a_enable_load: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        (tick && load_pend_q && !cnt_wr)
        |=> count_q == $past(restart_q))
        else $error("enable did not load restart value");

    a_wrap_flag: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        wrap_evt |=> wrap_q && evt_status_q && count_q == 24'h00_0000)
        else $error("wrap did not set flags");

    a_zero_nowrap: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        (count_q == 24'h00_0000)
        |=> !$rose(wrap_q) && !$rose(evt_status_q))
        else $error("wrap raised from zero count");

    a_count_clear: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        cnt_wr |=> count_q == 24'h00_0000 && !wrap_q)
        else $error("count write did not clear");

    a_stop_hold: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        (stop_s && !cnt_wr) |=> $stable(count_q) && $stable(div_q))
        else $error("count moved while clock stopped");

    a_rsv_zero: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        ($past(csr_rd) || $past(acc_rd && hit(address, `STC_OFF_COUNT)))
        |-> readdata[31:24] == 8'h00)
        else $error("reserved bits read nonzero");

    a_irq_level: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        (evt_status_q && !(acc_wr && hit(address, `STC_OFF_EVT_CLEAR)))
        |=> evt_status_q && irq == evt_enable_q)
        else $error("event status lost or interrupt out of step");

    a_restart_hold: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        (acc_wr && hit(address, `STC_OFF_RESTART) && !tick && !cnt_wr)
        |=> $stable(count_q))
        else $error("restart write moved the count");

    a_count_read: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        (acc_rd && hit(address, `STC_OFF_COUNT))
        |=> readdata == {8'h00, $past(count_q)})
        else $error("count read returned another value");

    a_fast_source: assert property (@(posedge clk_sys)
        disable iff (!reset_n)
        (en_q && src_q && !halt_s && !stop_s) |-> tick)
        else $error("undivided source missed a tick");

endmodule

/* File: verification/stc_tick_timer_tb.sv */
`timescale 1ns/1ps
`include "stc_consts.svh"
module stc_tick_timer_tb;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [31:0] address = 32'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0] byteenable = 4'hf;
    logic debug_halt_in = 1'b0;
    logic clock_stop_in = 1'b0;
    logic [31:0] readdata;
    logic waitrequest;
    logic tick_exc_req;
    logic irq;
    logic [31:0] rd;
    logic [31:0] held;
    int bad_count = 0;
    int checks = 0;
    int p;
    int q;

    always #2.5 clk_sys = ~clk_sys;

    stc_tick_timer u_dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .debug_halt_in(debug_halt_in),
        .clock_stop_in(clock_stop_in), .tick_exc_req(tick_exc_req),
        .irq(irq)
    );

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Request held until an edge that sees waitrequest low
    task automatic bus(input logic wr, input logic [31:0] a,
                       input logic [31:0] d);
        int k;
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        for (k = 0; k < 20; k++) begin
            @(posedge clk_sys);
            if (waitrequest === 1'b0) break;
        end
        if (k == 20) begin
            chk("bus answer", 32'h0, 32'h1);
            complete_run();
        end
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        // One idle edge so the next call never re-raises in this step
        @(posedge clk_sys);
    endtask

    task automatic rchk(input string what, input logic [31:0] a,
                        input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(what, rd, exp);
    endtask

    // Cycles up to and including the next request pulse
    task automatic gap(output int c);
        for (c = 1; c <= 300; c++) begin
            @(negedge clk_sys);
            if (tick_exc_req === 1'b1) break;
        end
        if (c > 300) begin
            chk("pulse wait", 32'h0, 32'h1);
            complete_run();
        end
        @(posedge clk_sys);
    endtask

    task automatic pulses(input int len, output int n);
        n = 0;
        repeat (len) begin
            @(negedge clk_sys);
            if (tick_exc_req === 1'b1) n++;
        end
        @(posedge clk_sys);
    endtask

    initial begin
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        rchk("csr", `STC_OFF_CSR, 32'h4);
        rchk("restart", `STC_OFF_RESTART, 32'h0);
        rchk("count", `STC_OFF_COUNT, 32'h0);
        bus(1'b1, `STC_OFF_CALIBRATION_REG, 32'h0);
        rchk("calibration_reg", `STC_OFF_CALIBRATION_REG, `STC_CALIBRATION_REG_VALUE);
        rchk("unmapped", 32'he000e030, 32'h0);
        $display("reset values done");
        bus(1'b1, `STC_OFF_RESTART, 32'hffffffff);
        rchk("restart rsvd", `STC_OFF_RESTART, 32'h00ffffff);
        byteenable <= 4'h3;
        bus(1'b1, `STC_OFF_RESTART, 32'h0);
        byteenable <= 4'hf;
        rchk("partial", `STC_OFF_RESTART, 32'h00ffffff);
        bus(1'b1, `STC_OFF_CSR, 32'hffffffff);
        rchk("csr rsvd", `STC_OFF_CSR, 32'h7);
        bus(1'b1, `STC_OFF_RESTART, 32'h3);
        bus(1'b0, `STC_OFF_COUNT, 32'h0);
        chk("count kept", 32'(rd > 32'h3), 32'h1);
        chk("count runs", 32'(rd < 32'hffffff), 32'h1);
        $display("reserved bits done");
        // Clearing the count forces a reload of the new value
        bus(1'b1, `STC_OFF_COUNT, 32'hdeadbeef);
        gap(p);
        gap(p);
        chk("period fast", p, 4);
        bus(1'b1, `STC_OFF_CSR, 32'h3);
        gap(p);
        gap(p);
        chk("period div8", p, 32);
        $display("periods done");
        for (int n = 0; n < 2; n++) begin
            {clock_stop_in, debug_halt_in} <= n ? 2'b10 : 2'b01;
            repeat (4) @(posedge clk_sys);
            bus(1'b0, `STC_OFF_COUNT, 32'h0);
            held = rd;
            repeat (20) @(posedge clk_sys);
            rchk("frozen", `STC_OFF_COUNT, held);
            bus(1'b0, `STC_OFF_CSR, 32'h0);
            if (n == 0) chk("flag set", rd, 32'h10003);
            rchk("flag clr", `STC_OFF_CSR, 32'h3);
            {clock_stop_in, debug_halt_in} <= 2'b00;
            @(posedge clk_sys);
        end
        $display("freeze done");
        bus(1'b1, `STC_OFF_CSR, 32'h5);
        pulses(40, p);
        chk("no request", p, 0);
        debug_halt_in <= 1'b1;
        repeat (4) @(posedge clk_sys);
        bus(1'b1, `STC_OFF_COUNT, 32'h1);
        rchk("count wr", `STC_OFF_COUNT, 32'h0);
        rchk("flag wr", `STC_OFF_CSR, 32'h5);
        debug_halt_in <= 1'b0;
        bus(1'b1, `STC_OFF_CSR, 32'h0);
        bus(1'b1, `STC_OFF_EVT_ENABLE, 32'h1);
        chk("irq on", 32'(irq), 32'h1);
        bus(1'b1, `STC_OFF_EVT_ENABLE, 32'h0);
        chk("irq mask", 32'(irq), 32'h0);
        bus(1'b1, `STC_OFF_EVT_CLEAR, 32'h1);
        bus(1'b1, `STC_OFF_EVT_ENABLE, 32'h1);
        chk("irq clr", 32'(irq), 32'h0);
        rchk("status", `STC_OFF_EVT_STATUS, 32'h0);
        $display("events done");
        bus(1'b1, `STC_OFF_RESTART, 32'h0);
        bus(1'b1, `STC_OFF_CSR, 32'h7);
        pulses(40, q);
        chk("zero reload", q, 0);
        rchk("zero flag", `STC_OFF_CSR, 32'h7);
        chk("zero irq", 32'(irq), 32'h0);
        $display("zero restart done");
        bus(1'b1, `STC_OFF_CSR, 32'h0);
        bus(1'b1, `STC_OFF_RESTART, 32'h5);
        bus(1'b1, `STC_OFF_CSR, 32'h7);
        // Load lands one edge after the write, then five counts
        gap(p);
        chk("one shot", p, 5);
        chk("irq wrap", 32'(irq), 32'h1);
        $display("single shot done");
        reset_n <= 1'b0;
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        rchk("csr again", `STC_OFF_CSR, 32'h4);
        rchk("count again", `STC_OFF_COUNT, 32'h0);
        chk("irq again", 32'(irq), 32'h0);
        $display("second reset done");
        complete_run();
    end
endmodule
